// File: rtl/pcf_pkg.sv
// package: register map, mode codes, reset values and gate timing
// assumes a 100 MHz core clock and a byte-addressed classic wishbone bus
`default_nettype none
package pcf_pkg;
  typedef logic [31:0] pcf_word_t;

  // word indices of the register groups; byte address is index * 4
  localparam logic [5:0] MODE_BASE_IDX = 6'h00;
  localparam logic [5:0] FILT_BASE_IDX = 6'h08;
  localparam logic [5:0] CNT_BASE_IDX = 6'h10;
  localparam int NUM_CH = 8;
  localparam int NUM_FILT = 3;
  localparam int FILT_W = 16;

  // mode code fields
  localparam int MODE_INV_BIT = 7;
  localparam logic [6:0] MODE_DIR_PULSE = 7'h00;
  localparam logic [6:0] MODE_UP_DOWN = 7'h01;
  localparam logic [6:0] MODE_FREQ_AUTO = 7'h02;
  localparam logic [6:0] MODE_UP_COUNT = 7'h03;
  localparam logic [6:0] MODE_FREQ_LOW = 7'h06;
  localparam logic [6:0] MODE_FREQ_HIGH = 7'h0A;

  // reset values
  localparam logic [7:0] MODE_RST = 8'h03;
  localparam logic [15:0] FILT_RST = 16'h0000;
  localparam logic [31:0] CNT_RST = 32'h00000000;

  // gate times in milliseconds and their cycle counts
  localparam int unsigned CORE_CLK_KHZ = 100000;
  localparam int unsigned AUTO_GATE_MS = 250;
  localparam int unsigned LOW_GATE_MS = 1000;
  localparam int unsigned HIGH_GATE_MS = 100;
  localparam int unsigned AUTO_GATE_CYC_DEF = AUTO_GATE_MS * CORE_CLK_KHZ;
  localparam int unsigned LOW_GATE_CYC_DEF = LOW_GATE_MS * CORE_CLK_KHZ;
  localparam int unsigned HIGH_GATE_CYC_DEF = HIGH_GATE_MS * CORE_CLK_KHZ;
endpackage : pcf_pkg
`default_nettype wire

// File: rtl/pcf_filt_if.sv
// interface: one input line into its noise filter and the filtered level
// assumes the filter runs on the same clock as its user
`default_nettype none
interface pcf_filt_if;
  logic raw;
  logic [15:0] width;
  logic clean;
  modport filt (input raw, input width, output clean);
  modport user (output raw, output width, input clean);
endinterface : pcf_filt_if
`default_nettype wire

// File: rtl/pcf_filter.sv
// module: pulse-width noise filter for one synchronised input line
// assumes raw is already synchronised to clk
`default_nettype none
module pcf_filter (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  pcf_filt_if.filt port
);
  import pcf_pkg::*;

  typedef struct packed {
    logic [15:0] run;
    logic clean;
  } pcf_filt_st_t;

  pcf_filt_st_t q, d;

  // a new level is taken only after it stood width cycles; 0 passes all
  always_comb begin
    d = q;
    if (port.raw == q.clean) begin
      d.run = 16'h0000;
    end else if (17'(q.run) + 17'h1 >= {1'b0, port.width}) begin // RL9
      d.clean = port.raw;
      d.run = 16'h0000;
    end else begin
      d.run = q.run + 16'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign port.clean = q.clean;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence glitch_s;
    ce && port.width >= 16'h2 && q.run == 16'h0 && port.raw != q.clean
      ##1 ce && port.raw == q.clean;
  endsequence

  filt_pass_a: assert property (ce && port.width == 16'h0 && // RL9
      port.raw != q.clean |=> q.clean == $past(port.raw))
    else $error("unfiltered input not passed after one cycle");
  filt_reject_a: assert property (glitch_s |-> q.clean == $past(q.clean)) // RL9
    else $error("one-cycle glitch passed a nonzero filter");
endmodule : pcf_filter
`default_nettype wire

// File: rtl/pcf_top.sv
// module: eight-input pulse counter and frequency meter, wishbone slave
// assumes PULSE_IN is asynchronous; bus master is classic single cycle
// Contract
// RL1 - code 0 dir/pulse pairs, code 1 up/down pairs, code 3 up count
// RL2 - codes 80, 81, 83 act as 0, 1, 3 on inverted input
// RL3 - codes 2, 6, A measure frequency with auto, low, high gate time
// RL4 - codes 82, 86, 8A measure frequency on inverted input
// RL5 - software gives both channels of a counting pair the same code
// RL6 - in eight-channel use each channel has its own independent code
// RL7 - up count is signed 32-bit from zero, wrapping max to min
// RL8 - software keeps paired counts inside the signed 32-bit range
// RL9 - pair noise filter zero passes all, else rejects narrow pulses; the code has three filters, one shared by inputs 5-8
// RL10 - dir/pulse: one input direction, other pulses; up/down: inc and dec
//
// Added by the designer: the Wishbone slave port and the register addresses.
`default_nettype none
module pcf_top #(
  parameter int unsigned AUTO_GATE_CYCLES = pcf_pkg::AUTO_GATE_CYC_DEF,
  parameter int unsigned LOW_GATE_CYCLES = pcf_pkg::LOW_GATE_CYC_DEF,
  parameter int unsigned HIGH_GATE_CYCLES = pcf_pkg::HIGH_GATE_CYC_DEF
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic [7:0] PULSE_IN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire pcf_pkg::pcf_word_t WB_DAT_I,
  output pcf_pkg::pcf_word_t WB_DAT_O,
  output logic WB_ACK_O
);
  import pcf_pkg::*;

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] prev;
    logic [7:0][7:0] mode;
    logic [2:0][15:0] filt;
    logic [7:0][31:0] cnt;
    logic [7:0][31:0] acc;
    logic [7:0][31:0] gate;
    logic ack;
    logic [31:0] rdat;
  } pcf_top_st_t;

  pcf_top_st_t q, d;
  logic [7:0] clean;
  logic [7:0] inp;
  logic [7:0] rise;
  logic hit;
  logic [5:0] idx;
  logic [7:0] wr_ch;

  assign hit = WB_CYC_I & WB_STB_I & ~q.ack;
  assign idx = WB_ADR_I[7:2];

  pcf_filt_if fif[NUM_CH] ();

  // filters are shared by input group: 1-2, 3-4, 5-8
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    localparam int FSEL = (i < 2) ? 0 : ((i < 4) ? 1 : 2);
    assign fif[i].raw = q.s2[i];
    assign fif[i].width = q.filt[FSEL]; // RL9
    pcf_filter u_filt (
      .clk(CORE_CLK),
      .rst(RST),
      .ce(CE),
      .port(fif[i])
    );
    assign clean[i] = fif[i].clean;
    assign inp[i] = clean[i] ^ q.mode[i][MODE_INV_BIT]; // RL2 RL4
    assign wr_ch[i] = hit & WB_WE_I &
        (idx == MODE_BASE_IDX + 6'(i) || idx == CNT_BASE_IDX + 6'(i));
  end

  assign rise = inp & ~q.prev;

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [31:0] gate_len(input logic [6:0] base);
    case (base)
      MODE_FREQ_LOW: gate_len = 32'(LOW_GATE_CYCLES);
      MODE_FREQ_HIGH: gate_len = 32'(HIGH_GATE_CYCLES);
      default: gate_len = 32'(AUTO_GATE_CYCLES);
    endcase
  endfunction : gate_len

  always_comb begin
    logic [6:0] base;
    logic [6:0] lbase;
    logic [31:0] acc_n;
    logic [31:0] merged;
    base = 7'h00;
    lbase = 7'h00;
    acc_n = 32'h0;
    merged = 32'h0;
    d = q;
    d.s1 = PULSE_IN;
    d.s2 = q.s1;
    d.prev = inp;
    d.ack = hit;
    for (int i = 0; i < NUM_CH; i++) begin
      base = q.mode[i][6:0];
      lbase = q.mode[i & 6][6:0];
      if (lbase == MODE_DIR_PULSE || lbase == MODE_UP_DOWN) begin // RL1
        // pair count lives in the even channel; odd input is the partner
        if ((i & 1) == 0) begin
          if (lbase == MODE_DIR_PULSE) begin
            if (rise[i]) begin // RL10
              d.cnt[i] = inp[i | 1] ? q.cnt[i] + 32'h1 : q.cnt[i] - 32'h1;
            end
          end else if (rise[i] & ~rise[i | 1]) begin // RL10
            d.cnt[i] = q.cnt[i] + 32'h1;
          end else if (rise[i | 1] & ~rise[i]) begin
            d.cnt[i] = q.cnt[i] - 32'h1;
          end
        end
      end else if (base == MODE_UP_COUNT) begin // RL6
        if (rise[i]) begin
          d.cnt[i] = q.cnt[i] + 32'h1; // RL7
        end
      end else if (base == MODE_FREQ_AUTO || base == MODE_FREQ_LOW ||
          base == MODE_FREQ_HIGH) begin // RL3
        acc_n = q.acc[i] + {31'h0, rise[i]};
        if (q.gate[i] >= gate_len(base) - 32'h1) begin
          d.cnt[i] = acc_n;
          d.acc[i] = 32'h0;
          d.gate[i] = 32'h0;
        end else begin
          d.acc[i] = acc_n;
          d.gate[i] = q.gate[i] + 32'h1;
        end
      end
    end
    d.rdat = 32'h0;
    if (hit && !WB_WE_I) begin
      if (idx < FILT_BASE_IDX) begin
        d.rdat = {24'h0, q.mode[idx[2:0]]};
      end else if (idx < FILT_BASE_IDX + 6'(NUM_FILT)) begin
        d.rdat = {16'h0, q.filt[2'(idx - FILT_BASE_IDX)]};
      end else if (idx >= CNT_BASE_IDX && idx < CNT_BASE_IDX + 6'(NUM_CH)) begin
        d.rdat = q.cnt[idx[2:0]];
      end
    end
    if (hit && WB_WE_I) begin
      if (idx < FILT_BASE_IDX) begin
        // a new code restarts the channel from zero
        if (WB_SEL_I[0]) begin
          d.mode[idx[2:0]] = WB_DAT_I[7:0];
          // seed the edge detector with the new polarity: no false edge
          d.prev[idx[2:0]] = clean[idx[2:0]] ^ WB_DAT_I[MODE_INV_BIT]; // RL7
          d.cnt[idx[2:0]] = CNT_RST;
          d.acc[idx[2:0]] = 32'h0;
          d.gate[idx[2:0]] = 32'h0;
        end
      end else if (idx < FILT_BASE_IDX + 6'(NUM_FILT)) begin
        merged = merge({16'h0, q.filt[2'(idx - FILT_BASE_IDX)]},
            WB_DAT_I, WB_SEL_I);
        d.filt[2'(idx - FILT_BASE_IDX)] = merged[15:0];
      end else if (idx >= CNT_BASE_IDX && idx < CNT_BASE_IDX + 6'(NUM_CH)) begin
        d.cnt[idx[2:0]] = merge(q.cnt[idx[2:0]], WB_DAT_I, WB_SEL_I);
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      q <= '0;
      q.mode <= {NUM_CH{MODE_RST}};
      q.filt <= {NUM_FILT{FILT_RST}};
    end else if (CE) begin
      q <= d;
    end
  end

  assign WB_DAT_O = q.rdat;
  assign WB_ACK_O = q.ack;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  up_count_a: assert property (CE && q.mode[0] == 8'h03 && rise[0] && // RL1
      !wr_ch[0] |=> q.cnt[0] == $past(q.cnt[0]) + 32'h1)
    else $error("up count missed an edge");
  up_wrap_a: assert property (CE && q.mode[0] == 8'h03 && // RL7
      q.cnt[0] == 32'h7FFFFFFF && rise[0] && !wr_ch[0]
      |=> q.cnt[0] == 32'h80000000)
    else $error("up count did not wrap to minimum");
  inv_count_a: assert property (CE && q.mode[1] == 8'h83 && // RL2
      q.mode[0][6:1] != 6'h00 &&
      !clean[1] && q.prev[1] == 1'b0 && !wr_ch[1]
      |=> q.cnt[1] == $past(q.cnt[1]) + 32'h1)
    else $error("inverted up count missed a falling edge");
  dir_down_a: assert property (CE && q.mode[2] == 8'h00 && rise[2] && // RL10
      !inp[3] && !wr_ch[2] |=> q.cnt[2] == $past(q.cnt[2]) - 32'h1)
    else $error("direction low did not count down");
  updown_dec_a: assert property (CE && q.mode[4] == 8'h01 && // RL10
      rise[5] && !rise[4] && !wr_ch[4]
      |=> q.cnt[4] == $past(q.cnt[4]) - 32'h1)
    else $error("down input did not decrement");
  ch_indep_a: assert property (CE && q.mode[1][6:0] == MODE_UP_COUNT && // RL6
      q.mode[0][1] && rise[1] && !wr_ch[1]
      |=> q.cnt[1] == $past(q.cnt[1]) + 32'h1)
    else $error("neighbour code disturbed an up counter");

  sequence gate_end_s;
    CE && q.mode[6][6:0] == MODE_FREQ_AUTO && !wr_ch[6] &&
      q.gate[6] == 32'(AUTO_GATE_CYCLES) - 32'h1;
  endsequence

  freq_latch_a: assert property (gate_end_s |=> // RL3
      q.cnt[6] == $past(q.acc[6]) + {31'h0, $past(rise[6])} &&
      q.acc[6] == 32'h0 && q.gate[6] == 32'h0)
    else $error("frequency result not latched at gate end");
  gate_bound_a: assert property ((q.mode[6] == 8'h86 || // RL4
      q.mode[6] == 8'h8A) |-> q.gate[6] < gate_len(q.mode[6][6:0]))
    else $error("gate counter exceeded its selected length");
  bus_ack_a: assert property (CE && hit |=> WB_ACK_O ##1
      (!WB_ACK_O || !$past(CE)))
    else $error("bus ack not a single cycle after request");
endmodule : pcf_top
`default_nettype wire

// File: testbench/pcf_src_model.sv
// partner model: field pulse sources driving the eight counter inputs
// assumes the bench calls its tasks; lines change just after clk rises
`default_nettype none
module pcf_src_model (
  input wire logic clk,
  output logic [7:0] lines
);
  timeunit 1ns;
  timeprecision 1ns;
  logic run = 1'b0;
  int ph = 0;
  initial lines = 8'h00;
  // square wave on channel 6 for frequency runs, period 10 cycles
  always @(posedge clk) begin
    if (run) begin
      ph = (ph + 1) % 5;
      if (ph == 0) lines[6] <= ~lines[6];
    end
  end
  // level change, then time for sync, filter and edge detect
  task automatic set(input int ch, input logic v);
    @(posedge clk);
    lines[ch] <= v;
    repeat (12) @(posedge clk);
  endtask : set
  task automatic pulse(input int ch, input int hi);
    @(posedge clk);
    lines[ch] <= 1'b1;
    repeat (hi) @(posedge clk);
    lines[ch] <= 1'b0;
    repeat (12) @(posedge clk);
  endtask : pulse
endmodule : pcf_src_model
`default_nettype wire

// File: testbench/tb.sv
// testbench: bus access, counting modes, filter and frequency checks
// assumes the pulse model on the inputs and one 100 MHz clock
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pcf_pkg::*;
  localparam int unsigned GA = 200, GL = 400, GH = 100;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  pcf_word_t wdat = 32'h0, rdat, dat_o;
  logic ack;
  logic [7:0] lines;
  logic ce = 1'b1;
  int error_cnt = 0, total_checks = 0;
  `define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin \
    error_cnt++; $display("unexpected %s exp %h got %h", n, e, a); end end
  pcf_top #(.AUTO_GATE_CYCLES(GA), .LOW_GATE_CYCLES(GL),
    .HIGH_GATE_CYCLES(GH)) dut (.CORE_CLK(clk), .RST(rst), .CE(ce),
    .PULSE_IN(lines), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o),
    .WB_ACK_O(ack));
  pcf_src_model src (.clk(clk), .lines(lines));
  always #5 clk = ~clk;
  task automatic wb(input logic w, input logic [7:0] a, input pcf_word_t d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic rchk(input string nm, input logic [7:0] a, pcf_word_t e);
    wb(1'b0, a, 32'h0);
    `CHK(nm, e, rdat)
  endtask : rchk
  task automatic t_reset();
    rchk("mode", 8'h00, {24'h0, MODE_RST});
    rchk("filter", 8'h20, 32'h0);
    rchk("count", 8'h40, 32'h0);
    wb(1'b1, 8'h80, 32'h12345678);
    rchk("unmapped", 8'h80, 32'h0);
    $display("done reset");
  endtask : t_reset
  task automatic t_wrap();
    wb(1'b1, 8'h40, 32'h7FFFFFFF);
    src.pulse(0, 4);
    rchk("wrap", 8'h40, 32'h80000000);
    src.pulse(0, 4);
    rchk("wrap next", 8'h40, 32'h80000001);
    $display("done wrap");
  endtask : t_wrap
  task automatic t_filter();
    wb(1'b1, 8'h20, 32'h5);
    wb(1'b1, 8'h40, 32'h0);
    src.pulse(0, 1);
    src.pulse(0, 2);
    rchk("narrow", 8'h40, 32'h0);
    src.pulse(0, 9);
    rchk("wide", 8'h40, 32'h1);
    wb(1'b1, 8'h20, 32'h0);
    $display("done filter");
  endtask : t_filter
  task automatic t_invert();
    wb(1'b1, 8'h04, 32'h83);
    wb(1'b1, 8'h40, 32'h0);
    src.set(0, 1'b1);
    src.set(1, 1'b1);
    rchk("plain rise", 8'h40, 32'h1);
    rchk("inv rise", 8'h44, 32'h0);
    src.set(0, 1'b0);
    src.set(1, 1'b0);
    rchk("plain fall", 8'h40, 32'h1);
    rchk("inv fall", 8'h44, 32'h1);
    $display("done invert");
  endtask : t_invert
  task automatic t_pairs();
    src.set(3, 1'b1);
    wb(1'b1, 8'h08, 32'h0);
    wb(1'b1, 8'h0C, 32'h0);
    repeat (3) src.pulse(2, 3);
    src.set(3, 1'b0);
    src.pulse(2, 3);
    rchk("dir pulse", 8'h48, 32'h2);
    wb(1'b1, 8'h10, 32'h1);
    wb(1'b1, 8'h14, 32'h1);
    repeat (2) src.pulse(4, 3);
    src.pulse(5, 3);
    rchk("up down", 8'h50, 32'h1);
    $display("done pairs");
  endtask : t_pairs
  task automatic t_freeze();
    wb(1'b1, 8'h40, 32'h0);
    @(posedge clk);
    ce <= 1'b0;
    src.pulse(0, 4);
    ce <= 1'b1;
    repeat (6) @(posedge clk);
    rchk("frozen", 8'h40, 32'h0);
    $display("done freeze");
  endtask : t_freeze
  task automatic t_freq();
    logic [7:0] fc[6] = '{8'h02, 8'h06, 8'h0A, 8'h82, 8'h86, 8'h8A};
    int unsigned fg[6] = '{GA, GL, GH, GA, GL, GH};
    int unsigned e;
    src.run = 1'b1;
    for (int i = 0; i < 6; i++) begin
      e = fg[i] / 10;
      wb(1'b1, 8'h18, {24'h0, fc[i]});
      repeat (fg[i] + 10) @(posedge clk);
      wb(1'b0, 8'h58, 32'h0);
      `CHK("freq", 1'b1, (rdat >= e - 1 && rdat <= e + 1))
    end
    src.run = 1'b0;
    $display("done frequency");
  endtask : t_freq
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_wrap();
    t_filter();
    t_invert();
    t_pairs();
    t_freeze();
    t_freq();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    summarize();
  end
endmodule : tb
`default_nettype wire
